// *** pio_periph.sv ***
/*
  Peripheral controller on the programmed I/O bus: an output channel that
  receives words from the processor and an input channel that supplies them,
  each with its own busy/done flag and skip gate, sharing one interrupt request.
  Assumes processor pins arrive asynchronously and open-drain lines are
  resolved outside, low while any enable is high.
*/
// Function
// [RULE1] Processor treats opcode 6 in bits 0-2 as I/O transfer.
// [RULE2] Processor stretches the cycle to 4.25 us and enables pulses.
// [RULE3] Slow cycle with third timing pulse starts I/O and holds timing.
// [RULE4] Three time states gated by bits 11, 10, 9 give three pulses.
// [RULE5] A pulse appears only when its bit is one; timing never changes.
// [RULE6] Processor strobes the interface lines at the end of each pulse.
// [RULE7] After the third state the hold is cleared and timing restarts.
// [RULE8] Every I/O instruction uses the same stretched cycle.
// [RULE9] Event 1 skips, event 2 clears flags or AC, event 3 moves data.
// [RULE10] Processor buses true and complement select bits 3 to 8.
// [RULE11] A channel is enabled only by its own code and regenerates pulses.
// [RULE12] Each group of three commands needs a channel with a distinct code.
// [RULE13] Channel decodes six chosen-polarity lines plus two qualifiers, low output.
// [RULE14] Selected channel gives positive command pulses and inverted copies.
// [RULE15] Commands go to skip, input, output gates or AC clear.
// [RULE16] Skip gate grounds the skip line when flag and command are true.
// [RULE17] Processor samples skip at pulse end and increments PC by one.
// [RULE18] Output device strobes the buffered AC into its register on command.
// [RULE19] Input device drives its register onto the AC input bus on command.
// [RULE20] Busy/done flag; a command with flag set pulses the skip line.
// [RULE21] All transfers go through the 12-bit accumulator in parallel.
// [RULE22] An interrupt request makes the processor save state and service; the model saves nothing and only sets pc to 1.
// [RULE23] A grounded AC input line sets that accumulator bit.
// [RULE24] Without AC clear, the loaded word ORs with the old contents.
// [RULE25] Lines not from flip-flops are asserted when high.
// [RULE26] Processor pulses never overlap; reset clears the hold flip-flop.
`timescale 1ns/1ps
module pio_periph #(
  parameter logic [pio_pkg::SEL_W-1:0] OUT_CODE = pio_pkg::OUT_CODE_DEF,
  parameter logic [pio_pkg::SEL_W-1:0] IN_CODE  = pio_pkg::IN_CODE_DEF
) (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  // Processor bus, sampled
  input  wire pio_pkg::pio_bus_type       bus_in,
  // Open-drain lines: level seen, value driven, enable
  input  wire pio_pkg::pio_drive_type     line_in,
  output pio_pkg::pio_drive_type          line_out,
  output pio_pkg::pio_drive_type          line_oe_out,
  // Device enable and interrupt enable
  input  wire logic                       dev_enable_in,
  input  wire logic                       irq_enable_in,
  // Words received from the processor
  output logic [pio_pkg::WORD_W-1:0]      out_data_out,
  output logic                            out_valid_out,
  input  wire logic                       out_ack_in,
  // Words sent to the processor
  input  wire logic [pio_pkg::WORD_W-1:0] in_data_in,
  input  wire logic                       in_valid_in,
  output logic                            in_ready_out,
  // Selection status
  output logic                            out_selected_n_out,
  output logic                            in_selected_n_out
);
  import pio_pkg::*;

  generate
    if (OUT_CODE == IN_CODE) begin : g_code_check
      $error("pio_periph: the two channels need distinct select codes");  // [RULE12]
    end
  endgenerate

  pio_bus_type       bus_meta;
  pio_bus_type       bus_sync;
  pio_cmd_type       processor_io_pulse;
  pio_cmd_type       out_cmd;
  pio_cmd_type       in_cmd;
  pio_cmd_type       out_cmd_prev;
  pio_cmd_type       in_cmd_prev;
  pio_cmd_type       out_rise;
  pio_cmd_type       in_rise;
  pio_out_state_type out_state;
  logic              in_done;
  logic [WORD_W-1:0] in_word;
  pio_drive_type     next_drive;
  pio_drive_type     drive;
  logic [QUAL_W-1:0] qual;

  // Two-stage synchroniser for every processor pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_meta <= '0;
      bus_sync <= '0;
    end else begin
      bus_meta <= bus_in;
      bus_sync <= bus_meta;
    end
  end

  // Pulses are positive when asserted
  assign processor_io_pulse  = {bus_sync.pulse_first, bus_sync.pulse_second, bus_sync.pulse_fourth}; // [RULE25]
  assign qual = {dev_enable_in, 1'b1};

  pio_selector #(.CODE(OUT_CODE)) u_out_sel (
    .sel_true_in    (bus_sync.sel_true),
    .sel_comp_in    (bus_sync.sel_comp),
    .qual_in        (qual),
    .iop_in         (processor_io_pulse),
    .selected_n_out (out_selected_n_out),
    .cmd_out        (out_cmd),
    .cmd_n_out      ()
  );

  pio_selector #(.CODE(IN_CODE)) u_in_sel (
    .sel_true_in    (bus_sync.sel_true),
    .sel_comp_in    (bus_sync.sel_comp),
    .qual_in        (qual),
    .iop_in         (processor_io_pulse),
    .selected_n_out (in_selected_n_out),
    .cmd_out        (in_cmd),
    .cmd_n_out      ()
  );

  // Leading edges of command pulses
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_cmd_prev <= '0;
      in_cmd_prev  <= '0;
    end else begin
      out_cmd_prev <= out_cmd;
      in_cmd_prev  <= in_cmd;
    end
  end

  assign out_rise = out_cmd & ~out_cmd_prev;
  assign in_rise  = in_cmd & ~in_cmd_prev;

  // Output channel: event 2 clears the flag, event 3 strobes the word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_state <= OUT_DONE;
    end else begin
      unique case (out_state)
        OUT_DONE: begin
          if (out_rise.fourth) begin
            out_state <= OUT_BUSY;                                    // [RULE18]
          end else if (out_rise.second) begin
            out_state <= OUT_IDLE;                                    // [RULE9]
          end
        end
        OUT_IDLE: begin
          if (out_rise.fourth) begin
            out_state <= OUT_BUSY;                                    // [RULE18]
          end
        end
        OUT_BUSY: begin
          if (out_ack_in) begin
            out_state <= OUT_DONE;                                    // [RULE20]
          end
        end
        default: begin
          out_state <= OUT_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_data_out <= RST_WORD;
    end else if (out_rise.fourth) begin
      out_data_out <= bus_sync.arith;                                 // [RULE18] [RULE9]
    end
  end

  assign out_valid_out = (out_state == OUT_BUSY);

  // Input channel flag: user load sets it, event 2 clears it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_done <= RST_IN_DONE;
    end else if (in_valid_in && !in_done) begin
      in_done <= 1'b1;                                                // [RULE20]
    end else if (in_rise.second) begin
      in_done <= 1'b0;                                                // [RULE9]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_word <= RST_WORD;
    end else if (in_valid_in && !in_done) begin
      in_word <= in_data_in;
    end
  end

  assign in_ready_out = !in_done;

  // Line drive, held for the whole command pulse so the processor
  // samples a settled level at its end
  always_comb begin
    next_drive        = '0;
    next_drive.skip   = (out_cmd.first && (out_state == OUT_DONE))
                        || (in_cmd.first && in_done);                 // [RULE16] [RULE20] [RULE15]
    next_drive.zero   = in_cmd.second;                                // [RULE15] [RULE9]
    next_drive.acc_in = in_cmd.fourth ? in_word : RST_WORD;           // [RULE19] [RULE21]
    next_drive.irq    = irq_enable_in && ((out_state == OUT_DONE) || in_done);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  // Open-drain: enable high grounds the line
  assign line_oe_out = drive;
  assign line_out    = '0;

endmodule

// *** pio_pkg.sv ***
/*
  Shared constants and carrier types for the peripheral-side programmed I/O bus port.
  Assumes one 40 MHz clock and processor bus pins that arrive asynchronously.
*/
package pio_pkg;

  localparam int SEL_W  = 6;
  localparam int WORD_W = 12;
  localparam int QUAL_W = 2;

  // Default select codes for the two channels (octal 34 and 35)
  localparam logic [SEL_W-1:0]  OUT_CODE_DEF = 6'h1C;
  localparam logic [SEL_W-1:0]  IN_CODE_DEF  = 6'h1D;

  // Values after reset
  localparam logic [WORD_W-1:0] RST_WORD     = 12'h000;
  localparam logic              RST_IN_DONE  = 1'b0;
  localparam logic              RST_LEVEL    = 1'b0;

  // Lines sampled from the processor bus
  typedef struct packed {
    logic              pulse_first;
    logic              pulse_second;
    logic              pulse_fourth;
    logic [SEL_W-1:0]  sel_true;
    logic [SEL_W-1:0]  sel_comp;
    logic [WORD_W-1:0] arith;
  } pio_bus_type;

  // Open-drain lines toward the processor
  typedef struct packed {
    logic              skip;
    logic              zero;
    logic              irq;
    logic [WORD_W-1:0] acc_in;
  } pio_drive_type;

  // One group of three pulses, event times 1, 2 and 3
  typedef struct packed {
    logic first;
    logic second;
    logic fourth;
  } pio_cmd_type;

  typedef enum logic [1:0] {
    OUT_DONE = 2'b00,
    OUT_IDLE = 2'b01,
    OUT_BUSY = 2'b10
  } pio_out_state_type;

  // Selected-code match over chosen-polarity select lines
  function automatic logic pio_code_match(input logic [SEL_W-1:0] sel_true,
                                          input logic [SEL_W-1:0] sel_comp,
                                          input logic [SEL_W-1:0] code);
    return &((sel_true & code) | (sel_comp & ~code));
  endfunction

endpackage

// *** pio_selector.sv ***
/*
  One device selector channel: decodes its select code and regenerates the
  three processor pulses as positive and inverted command pulses.
  Assumes its inputs are already synchronised to the local clock.
*/
`timescale 1ns/1ps
module pio_selector #(
  parameter logic [pio_pkg::SEL_W-1:0] CODE = pio_pkg::OUT_CODE_DEF
) (
  // Bussed select code and processor pulses
  input  wire logic [pio_pkg::SEL_W-1:0]  sel_true_in,
  input  wire logic [pio_pkg::SEL_W-1:0]  sel_comp_in,
  input  wire logic [pio_pkg::QUAL_W-1:0] qual_in,
  input  wire pio_pkg::pio_cmd_type       iop_in,
  // Selection and command pulses
  output logic                            selected_n_out,
  output pio_pkg::pio_cmd_type            cmd_out,
  output pio_pkg::pio_cmd_type            cmd_n_out
);
  import pio_pkg::*;

  // Six-line NAND with two qualifier inputs, low when selected
  assign selected_n_out = ~(pio_code_match(sel_true_in, sel_comp_in, CODE)
                            & (&qual_in));                              // [RULE11] [RULE13]
  assign cmd_out   = selected_n_out ? 3'h0 : iop_in;                   // [RULE14]
  assign cmd_n_out = ~cmd_out;                                         // [RULE14]

endmodule

// *** pio_periph_sva.sv ***
/* Port checker for pio_periph.
   Assumes a bound target and a bus held steady through each transfer. */
`timescale 1ns/1ps
module pio_periph_sva #(
  parameter logic [pio_pkg::SEL_W-1:0] OUT_CODE = pio_pkg::OUT_CODE_DEF,
  parameter logic [pio_pkg::SEL_W-1:0] IN_CODE  = pio_pkg::IN_CODE_DEF
) (
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire pio_pkg::pio_bus_type   bus_in,
  input wire pio_pkg::pio_drive_type line_out,
  input wire pio_pkg::pio_drive_type line_oe_out,
  input wire logic                   dev_enable_in,
  input wire logic                   irq_enable_in,
  input wire logic [11:0]            out_data_out,
  input wire logic                   out_valid_out,
  input wire logic                   out_ack_in,
  input wire logic                   in_valid_in,
  input wire logic                   in_ready_out,
  input wire logic                   out_selected_n_out
);
  import pio_pkg::*;
  logic [5:0] h_first, h_second, h_fourth, h_sel;
  wire logic  m_out;
  wire logic  m_in;
  assign m_out = bus_in.sel_true == OUT_CODE && bus_in.sel_comp == ~OUT_CODE;
  assign m_in  = bus_in.sel_true == IN_CODE && bus_in.sel_comp == ~IN_CODE;
  // Recent history of pulses and selection
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      h_first  <= 6'h00;
      h_second <= 6'h00;
      h_fourth <= 6'h00;
      h_sel    <= 6'h00;
    end else begin
      h_first  <= {h_first[4:0], bus_in.pulse_first};
      h_second <= {h_second[4:0], bus_in.pulse_second};
      h_fourth <= {h_fourth[4:0], bus_in.pulse_fourth};
      h_sel    <= {h_sel[4:0], (m_out || m_in) && dev_enable_in};
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_out_sel;
    (m_out && dev_enable_in) [*4];
  endsequence
  sequence s_out_other;
    (!m_out) [*4];
  endsequence
  a_line_value_low: assert property (line_out == 15'h0000)
    else $error("open-drain value not low");
  a_skip_from_first: assert property (line_oe_out.skip |-> (|h_first) && (|h_sel))
    else $error("skip driven without first pulse");
  a_zero_from_second: assert property (line_oe_out.zero |-> (|h_second) && (|h_sel))
    else $error("clear driven without second pulse");
  a_acc_from_fourth: assert property ((|line_oe_out.acc_in) |-> (|h_fourth) && (|h_sel))
    else $error("input bus driven without fourth pulse");
  a_sel_out_match: assert property (s_out_sel |-> !out_selected_n_out)
    else $error("output channel not selected");
  a_sel_out_other: assert property (s_out_other |-> out_selected_n_out)
    else $error("output channel selected by other code");
  a_out_strobe: assert property ($rose(out_valid_out) |->
      out_data_out == $past(bus_in.arith, 3) && (|h_fourth))
    else $error("received word not the bus word");
  a_out_holds: assert property (out_valid_out && !out_ack_in |=> out_valid_out)
    else $error("word dropped before ack");
  a_out_taken: assert property (out_valid_out && out_ack_in |=> !out_valid_out)
    else $error("word kept after ack");
  a_in_taken: assert property (in_valid_in && in_ready_out |=> !in_ready_out)
    else $error("input flag not set on load");
  a_irq_gated: assert property (line_oe_out.irq |-> $past(irq_enable_in))
    else $error("request without enable");
endmodule

bind pio_periph pio_periph_sva #(.OUT_CODE(OUT_CODE), .IN_CODE(IN_CODE)) i_sva (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in), .line_out(line_out),
  .line_oe_out(line_oe_out), .dev_enable_in(dev_enable_in), .irq_enable_in(irq_enable_in),
  .out_data_out(out_data_out), .out_valid_out(out_valid_out), .out_ack_in(out_ack_in),
  .in_valid_in(in_valid_in), .in_ready_out(in_ready_out),
  .out_selected_n_out(out_selected_n_out));

// *** pio_cpu.sv ***
/* Processor end of the programmed I/O bus: times transfer instructions,
   keeps accumulator and program counter. Assumes lines pulled high. */
`timescale 1ns/1ps
module pio_cpu (
  // Clock, reset and bus
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  output pio_pkg::pio_bus_type        bus_out,
  input  wire pio_pkg::pio_drive_type line_in
);
  import pio_pkg::*;
  logic [WORD_W-1:0] acc;
  logic [WORD_W-1:0] pc;
  logic              hold;
  initial begin
    bus_out = 27'h0000000;
    acc     = 12'h000;
    pc      = 12'h000;
    hold    = 1'b0;
  end
  always @(negedge rst_n_in) hold = 1'b0;
  task automatic io_transfer_instruction(input logic [WORD_W-1:0] ins, output logic skip);
    skip = 1'b0;
    if (ins[11:9] == 3'h6) begin
      @(posedge clk_in);
      #1;
      hold = 1'b1;
      bus_out.arith    = acc;
      bus_out.sel_true = ins[8:3];
      bus_out.sel_comp = ~ins[8:3];
      // Same three time states whatever bits are set
      for (int t = 0; t < 3; t++) begin
        repeat (10) @(posedge clk_in);
        #1;
        bus_out.pulse_first  = ins[0] && t == 0;
        bus_out.pulse_second = ins[1] && t == 1;
        bus_out.pulse_fourth = ins[2] && t == 2;
        repeat (29) @(posedge clk_in);
        #1;
        if (!line_in.skip) skip = 1'b1;
        if (!line_in.zero) acc = 12'h000;
        acc = acc | ~line_in.acc_in;
        bus_out.arith = acc;
        @(posedge clk_in);
        #1;
        bus_out.pulse_first  = 1'b0;
        bus_out.pulse_second = 1'b0;
        bus_out.pulse_fourth = 1'b0;
        repeat (10) @(posedge clk_in);
      end
      repeat (19) @(posedge clk_in);
      #1;
      bus_out.sel_true = 6'h00;
      bus_out.sel_comp = 6'h3F;
      hold = 1'b0;
      pc = pc + 12'h001 + {11'h000, skip};
      if (!line_in.irq) pc = 12'h001;
    end
  endtask
endmodule

// *** pio_periph_test.sv ***
/* Bench for pio_periph driven by the processor model.
   Assumes lines pulled high and the bound checker. */
`timescale 1ns/1ps
module pio_periph_test;
  import pio_pkg::*;
  logic              clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  pio_bus_type       bus;
  pio_drive_type     line_in, line_out, line_oe;
  logic              dev_en = 1'b1, irq_en = 1'b0, out_ack = 1'b0, in_valid = 1'b0;
  logic              out_valid, in_ready, sk;
  logic              out_sel_n, in_sel_n;
  logic [WORD_W-1:0] out_data, in_data = 12'h000;
  int                n_errors = 0, n_checks = 0;
  always #12.5 clk_in = ~clk_in;
  assign line_in = (line_oe & line_out) | ~line_oe;
  pio_cpu i_cpu (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_out(bus), .line_in(line_in));
  pio_periph i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .line_in(line_in),
    .line_out(line_out), .line_oe_out(line_oe), .dev_enable_in(dev_en),
    .irq_enable_in(irq_en), .out_data_out(out_data), .out_valid_out(out_valid),
    .out_ack_in(out_ack), .in_data_in(in_data), .in_valid_in(in_valid),
    .in_ready_out(in_ready), .out_selected_n_out(out_sel_n), .in_selected_n_out(in_sel_n));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk1(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk12(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_output;
    i_cpu.acc = 12'hA5C;
    i_cpu.io_transfer_instruction(12'o6347, sk);
    chk1("out skip", 1'b1, sk);
    chk1("out valid", 1'b1, out_valid);
    chk12("out data", 12'hA5C, out_data);
    i_cpu.io_transfer_instruction(12'o6341, sk);
    chk1("busy skip", 1'b0, sk);
    out_ack = 1'b1;
    tick(1);
    out_ack = 1'b0;
    chk1("acked valid", 1'b0, out_valid);
    i_cpu.io_transfer_instruction(12'o6341, sk);
    chk1("done skip", 1'b1, sk);
    i_cpu.acc = 12'h5A3;
    i_cpu.io_transfer_instruction(12'o6344, sk);
    chk1("direct valid", 1'b1, out_valid);
    chk12("direct data", 12'h5A3, out_data);
    out_ack = 1'b1;
    tick(1);
    out_ack = 1'b0;
    chk1("direct acked", 1'b0, out_valid);
    $display("t_output finished");
  endtask
  task automatic t_input;
    in_data = 12'h3C1;
    in_valid = 1'b1;
    tick(1);
    in_valid = 1'b0;
    chk1("in ready", 1'b0, in_ready);
    i_cpu.acc = 12'h00F;
    i_cpu.io_transfer_instruction(12'o6357, sk);
    chk1("in skip", 1'b1, sk);
    chk12("in word", 12'h3C1, i_cpu.acc);
    chk1("ready again", 1'b1, in_ready);
    in_data = 12'h0F0;
    in_valid = 1'b1;
    tick(1);
    in_valid = 1'b0;
    i_cpu.io_transfer_instruction(12'o6355, sk);
    chk12("or word", 12'h3F1, i_cpu.acc);
    $display("t_input finished");
  endtask
  task automatic t_select;
    i_cpu.acc = 12'h123;
    i_cpu.io_transfer_instruction(12'o6447, sk);
    chk1("other skip", 1'b0, sk);
    chk12("other acc", 12'h123, i_cpu.acc);
    dev_en = 1'b0;
    i_cpu.io_transfer_instruction(12'o6341, sk);
    chk1("qual skip", 1'b0, sk);
    dev_en = 1'b1;
    i_cpu.io_transfer_instruction(12'o6351, sk);
    chk1("in chan skip", 1'b1, sk);
    i_cpu.bus_out.sel_true = IN_CODE_DEF;
    i_cpu.bus_out.sel_comp = ~IN_CODE_DEF;
    tick(4);
    chk1("in selected", 1'b0, in_sel_n);
    chk1("out unselected", 1'b1, out_sel_n);
    i_cpu.bus_out.sel_true = OUT_CODE_DEF;
    i_cpu.bus_out.sel_comp = ~OUT_CODE_DEF;
    tick(4);
    chk1("out selected", 1'b0, out_sel_n);
    chk1("in unselected", 1'b1, in_sel_n);
    dev_en = 1'b0;
    tick(1);
    chk1("qual selected", 1'b1, out_sel_n);
    dev_en = 1'b1;
    i_cpu.bus_out.sel_true = 6'h00;
    i_cpu.bus_out.sel_comp = 6'h3F;
    tick(4);
    $display("t_select finished");
  endtask
  task automatic t_irq;
    irq_en = 1'b1;
    tick(3);
    chk1("irq on", 1'b1, line_oe.irq);
    irq_en = 1'b0;
    tick(3);
    chk1("irq off", 1'b0, line_oe.irq);
    $display("t_irq finished");
  endtask
  initial begin
    #(25 * 20000);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    chk1("reset oe", 1'b0, |line_oe);
    chk1("reset ready", 1'b1, in_ready);
    tick(3);
    t_output();
    t_input();
    t_select();
    t_irq();
    tally_and_finish();
  end
endmodule
